// ---- design/move_calc.sv ----
`timescale 1ns/1ns
`default_nettype none
module move_calc
  import pulse_pos_pkg::*;
(
  // decode link
  move_calc_if.calc m
);
  // compare first: the sign of a wrapped difference can point the wrong way
  wire        below = $signed(m.setting) < $signed(m.position);
  wire [31:0] gap   = below ? (m.position - m.setting)
                            : (m.setting - m.position);

  // absolute moves take size and sign from target against position
  assign m.count       = m.is_abs ? gap : (m.setting & REL_MAX); // see RL7
  assign m.dir_ccw     = m.is_abs ? below : m.ccw;               // see RL7
  assign m.refuse      = m.is_abs && !m.origin;              // see RL6
  assign m.clear_first = !m.is_abs && !m.origin;             // see RL4
endmodule : move_calc
`default_nettype wire

// ---- design/move_calc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// command decode travels from the top to the calculator
interface move_calc_if;
  logic        is_abs;
  logic        ccw;
  logic [31:0] setting;
  logic [31:0] position;
  logic        origin;
  logic [31:0] count;
  logic        dir_ccw;
  logic        refuse;
  logic        clear_first;
  modport top  (output is_abs, ccw, setting, position, origin,
                input count, dir_ccw, refuse, clear_first);
  modport calc (input is_abs, ccw, setting, position, origin,
                output count, dir_ccw, refuse, clear_first);
endinterface : move_calc_if
`default_nettype wire

// ---- design/pulse_pos_pkg.sv ----
package pulse_pos_pkg;
  // position counter geometry
  localparam int          POS_W        = 32;
  localparam logic [31:0] POS_ZERO     = 32'h0000_0000;
  localparam logic [31:0] REL_MAX      = 32'h7fff_ffff;
  localparam logic [31:0] ONE          = 32'h0000_0001;
  // pulse timing
  localparam int          PULSE_NS     = 80;
  localparam int          CLK_NS       = 8;
  localparam int          PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  PULSE_CYC_8  = 8'(PULSE_CYC);
  // register offsets (word addresses)
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h1;
  localparam logic [3:0]  ADDR_IRQ     = 4'h2;
  localparam logic [3:0]  ADDR_MASK    = 4'h3;
  localparam logic [3:0]  ADDR_POS     = 4'h4;
  localparam logic [3:0]  ADDR_PRESET  = 4'h5;
  localparam logic [3:0]  ADDR_TARGET  = 4'h6;
  localparam logic [3:0]  ADDR_CMD     = 4'h7;
  // control bits
  localparam int          CTRL_RESET_B = 0;
  // command word bits
  localparam int          CMD_ABS_B    = 0;
  localparam int          CMD_CCW_B    = 1;
  // interrupt bits
  localparam int          IRQ_DONE_B   = 0;
  localparam int          IRQ_ERR_B    = 1;
  localparam int          IRQ_W        = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HIGH  = 2'b01,
    ST_LOW   = 2'b11
  } move_state_t;
endpackage : pulse_pos_pkg

// ---- design/pulse_position.sv ----
// Summary of operation
// RL1: relative frame until origin, then absolute
// RL2: origin-undefined flag tracks origin state
// RL3: relative move outputs exactly commanded count
// RL4: relative frame clears counter before pulses
// RL5: absolute frame adds movement to counter
// RL6: absolute without origin refused, error flagged
// RL7: absolute move from target minus position
// RL8: counter is signed 32 bit
// RL9: host keeps relative count within positive range
// RL10: host gives signed absolute target
// RL11: origin defined by search or preset
// RL12: pulse reset control undefines origin
// RL13: leaving edit mode undefines origin
// RL14: count up clockwise, down counterclockwise
`timescale 1ns/1ns
`default_nettype none
module pulse_position
  import pulse_pos_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // controller events
  input  wire logic        search_done,
  input  wire logic        edit_mode,
  // pulse outputs to the driver, status flags and interrupt
  output logic             cw_pulse,
  output logic             ccw_pulse,
  output logic             origin_undef,
  output logic             busy,
  output logic             irq
);
  move_calc_if m ();

  move_state_t        state;
  move_state_t        next_state;
  logic signed [31:0] position;        // see RL8
  logic        [31:0] target;
  logic        [31:0] remain;
  logic        [7:0]  tick;
  logic               dir_ccw;
  logic               origin;
  logic               pulse_reset;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [1:0]         search_sync;
  logic [1:0]         edit_sync;
  logic               search_q;
  logic               edit_q;

  // pins are asynchronous: two flops before any logic reads them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      search_sync <= 2'h0;
      edit_sync   <= 2'h0;
      search_q    <= 1'b0;
      edit_q      <= 1'b0;
    end else begin
      search_sync <= {search_sync[0], search_done};
      edit_sync   <= {edit_sync[0], edit_mode};
      search_q    <= search_sync[1];
      edit_q      <= edit_sync[1];
    end
  end

  // register select, shared by every write decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
    return a == want;
  endfunction : hit

  // register decode
  wire wr_ctrl   = wr && hit(addr, ADDR_CTRL);
  wire wr_irq    = wr && hit(addr, ADDR_IRQ);
  wire wr_mask   = wr && hit(addr, ADDR_MASK);
  wire wr_preset = wr && hit(addr, ADDR_PRESET);
  wire wr_target = wr && hit(addr, ADDR_TARGET);
  wire wr_cmd    = wr && hit(addr, ADDR_CMD);
  wire search_rise = search_sync[1] && !search_q;
  wire edit_leave  = edit_q && !edit_sync[1];
  wire idle        = (state == ST_IDLE);

  // command decode feeds the move calculator
  assign m.is_abs   = wdata[CMD_ABS_B];
  assign m.ccw      = wdata[CMD_CCW_B];
  assign m.setting  = target;
  assign m.position = position;
  assign m.origin   = origin;

  move_calc u_calc (
    .m (m)
  );

  // a command is only taken when idle and not held in pulse reset
  wire cmd_go    = wr_cmd && idle && !pulse_reset;
  wire cmd_err   = cmd_go && m.refuse;                   // see RL6
  wire cmd_start = cmd_go && !m.refuse && (m.count != POS_ZERO);
  wire cmd_null  = cmd_go && !m.refuse && (m.count == POS_ZERO);
  wire step      = (state == ST_LOW) && (tick == 8'h00);
  wire last_step = step && (remain == ONE);
  wire done_ev   = last_step || cmd_null;

  // origin undefine wins over define so a reset is never missed
  wire org_clear = pulse_reset || edit_leave;            // see RL12 RL13
  wire org_set   = search_rise || wr_preset;             // see RL11
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      origin <= 1'b0;
    end else if (org_clear) begin
      origin <= 1'b0;
    end else if (org_set) begin
      origin <= 1'b1;
    end
  end
  assign origin_undef = !origin;                         // see RL1 RL2

  // control and setting registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulse_reset <= 1'b0;
      irq_mask    <= '0;
      target      <= POS_ZERO;
    end else begin
      if (wr_ctrl) pulse_reset <= wdata[CTRL_RESET_B];
      if (wr_mask) irq_mask <= wdata[IRQ_W-1:0];
      if (wr_target) target <= wdata;
    end
  end

  // sticky events: a new event beats the write-one clear
  wire [IRQ_W-1:0] irq_set = {cmd_err, done_ev};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irq ? wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // pulse sequencer: high half, low half, one count per pulse
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (cmd_start) next_state = ST_HIGH;
      ST_HIGH: if (pulse_reset) next_state = ST_IDLE;
               else if (tick == 8'h00) next_state = ST_LOW;
      ST_LOW:  if (pulse_reset || last_step) next_state = ST_IDLE;
               else if (tick == 8'h00) next_state = ST_HIGH;
      default: next_state = ST_IDLE;  // the unused code falls back to idle
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      tick  <= 8'h00;
    end else begin
      state <= next_state;
      tick  <= (next_state != state) ? PULSE_CYC_8 - 8'h01
                                     : (tick - 8'h01);
    end
  end

  // movement count and direction latched at command time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain  <= POS_ZERO;
      dir_ccw <= 1'b0;
    end else if (cmd_start) begin
      remain  <= m.count;                                // see RL3
      dir_ccw <= m.dir_ccw;
    end else if (step) begin
      remain  <= remain - ONE;
    end
  end

  // counter: preset, clear for relative frame, then count pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      position <= POS_ZERO;
    end else if (wr_preset && idle) begin
      position <= wdata;
    end else if ((cmd_start || cmd_null) && m.clear_first) begin
      position <= POS_ZERO;                              // see RL4
    end else if (step) begin
      position <= dir_ccw ? position - ONE : position + ONE; // see RL14 RL5
    end
  end

  // pulse pins come from flops: the driver counts edges, so a decode
  // glitch when state and direction change together would be a step
  wire next_dir  = cmd_start ? m.dir_ccw : dir_ccw;
  wire next_high = (next_state == ST_HIGH);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cw_pulse  <= 1'b0;
      ccw_pulse <= 1'b0;
    end else begin
      cw_pulse  <= next_high && !next_dir;
      ccw_pulse <= next_high && next_dir;
    end
  end
  assign busy = !idle;

  // read mux, data valid the cycle after the strobe
  wire [31:0] rd_mux =
    (addr == ADDR_CTRL)   ? {31'h0, pulse_reset} :
    (addr == ADDR_STATUS) ? {30'h0, busy, origin_undef} :
    (addr == ADDR_IRQ)    ? {30'h0, irq_stat} :
    (addr == ADDR_MASK)   ? {30'h0, irq_mask} :
    (addr == ADDR_POS)    ? position :
    (addr == ADDR_TARGET) ? target : 32'h0000_0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // checks
  // helper: pulses emitted since the command, kept apart from the
  // sequencer's own down counter so a slip in one shows in the other
  logic [31:0] move_len;
  logic [31:0] emitted;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      move_len <= POS_ZERO;
      emitted  <= POS_ZERO;
    end else if (cmd_start) begin
      move_len <= m.count;
      emitted  <= POS_ZERO;
    end else if (step) begin
      emitted  <= emitted + ONE;
    end
  end
  // direction an absolute move must take, by a plain signed compare
  wire target_below = $signed(target) < position;

  // origin bookkeeping
  a_flag_origin: assert property ( // see RL2
    @(posedge clk) disable iff (!rstn)
    origin_undef == !origin)
    else $error("origin flag mismatch");
  a_reset_undef: assert property ( // see RL12
    @(posedge clk) disable iff (!rstn)
    pulse_reset |=> !origin)
    else $error("pulse reset left origin defined");
  a_preset_defines: assert property ( // see RL11
    @(posedge clk) disable iff (!rstn)
    (wr_preset && !org_clear) |=> origin)
    else $error("preset did not define origin");
  a_search_defines: assert property ( // see RL11
    @(posedge clk) disable iff (!rstn)
    (search_rise && !org_clear) |=> origin)
    else $error("origin search did not define origin");
  a_edit_leave: assert property ( // see RL13
    @(posedge clk) disable iff (!rstn)
    edit_leave |=> !origin)
    else $error("leaving edit mode kept origin");
  a_preset_load: assert property ( // see RL11
    @(posedge clk) disable iff (!rstn)
    (wr_preset && idle) |=> position == $past(wdata))
    else $error("preset did not load the counter");

  // command acceptance and frame handling
  a_abs_refused: assert property ( // see RL6
    @(posedge clk) disable iff (!rstn)
    (wr_cmd && idle && !pulse_reset && wdata[CMD_ABS_B] && !origin)
      |=> (state == ST_IDLE) && irq_stat[IRQ_ERR_B])
    else $error("absolute command without origin not refused");
  a_err_quiet: assert property ( // see RL6
    @(posedge clk) disable iff (!rstn)
    cmd_err |=> !busy && !cw_pulse && !ccw_pulse)
    else $error("refused command moved the axis");
  a_rel_clear: assert property ( // see RL4
    @(posedge clk) disable iff (!rstn)
    (cmd_start && !origin && !wdata[CMD_ABS_B])
      |=> position == POS_ZERO)
    else $error("relative frame did not clear counter");
  a_null_clear: assert property ( // see RL4
    @(posedge clk) disable iff (!rstn)
    (cmd_null && !origin) |=> position == POS_ZERO)
    else $error("empty relative move did not clear counter");
  a_abs_keep: assert property ( // see RL1
    @(posedge clk) disable iff (!rstn)
    (cmd_start && origin) |=> position == $past(position))
    else $error("absolute frame lost the counter");
  a_load_count: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    cmd_start |=> remain == $past(m.count))
    else $error("movement count not taken");
  a_rel_dir: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    (cmd_start && !m.is_abs) |=> dir_ccw == $past(m.ccw))
    else $error("relative move took the wrong direction");
  a_abs_dir: assert property ( // see RL7
    @(posedge clk) disable iff (!rstn)
    (cmd_start && m.is_abs) |=> dir_ccw == $past(target_below))
    else $error("absolute move took the wrong direction");
  a_first_pulse: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    cmd_start |=> cw_pulse || ccw_pulse)
    else $error("accepted move did not start a pulse");

  // stepping and completion
  a_step_count: assert property ( // see RL14
    @(posedge clk) disable iff (!rstn)
    (step && !dir_ccw && !wr_preset)
      |=> position == $past(position) + 32'sd1)
    else $error("clockwise step did not count up");
  a_ccw_count: assert property ( // see RL14
    @(posedge clk) disable iff (!rstn)
    (step && dir_ccw && !wr_preset)
      |=> position == $past(position) - 32'sd1)
    else $error("counterclockwise step did not count down");
  a_one_dir: assert property ( // see RL14
    @(posedge clk) disable iff (!rstn)
    !(cw_pulse && ccw_pulse))
    else $error("both pulse outputs high");
  a_no_pulse_idle: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    idle |-> !cw_pulse && !ccw_pulse)
    else $error("pulse while idle");
  a_exact_count: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    last_step |-> emitted == move_len - ONE)
    else $error("move ended on the wrong pulse count");
  a_done_irq: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    last_step |=> idle && irq_stat[IRQ_DONE_B])
    else $error("finished move not reported");
  a_null_done: assert property ( // see RL3
    @(posedge clk) disable iff (!rstn)
    cmd_null |=> idle && irq_stat[IRQ_DONE_B])
    else $error("empty move not reported");
  a_reset_stop: assert property ( // see RL12
    @(posedge clk) disable iff (!rstn)
    pulse_reset |=> idle)
    else $error("pulse reset did not stop the move");

  // main scenarios
  c_rel_move: cover property (@(posedge clk) disable iff (!rstn)
    cmd_start && !origin);
  c_abs_move: cover property (@(posedge clk) disable iff (!rstn)
    cmd_start && origin);
  c_refused: cover property (@(posedge clk) disable iff (!rstn) cmd_err);
  c_done: cover property (@(posedge clk) disable iff (!rstn) last_step);
  c_null_move: cover property (@(posedge clk) disable iff (!rstn) cmd_null);
endmodule : pulse_position
`default_nettype wire

// ---- tb/motor_driver_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// stand-in for the motor driver: net step count of the axis
module motor_driver_model (
  // pulse inputs
  input  wire logic cw_pulse,
  input  wire logic ccw_pulse,
  // net steps, up for clockwise
  output int        steps
);
  initial steps = 0;
  // a driver steps on the leading edge, so a glitch would cost a step
  always @(posedge cw_pulse) steps = steps + 1;
  always @(posedge ccw_pulse) steps = steps - 1;
endmodule : motor_driver_model
`default_nettype wire

// ---- tb/pulse_position_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module pulse_position_bench;
  import pulse_pos_pkg::*;
  logic        clk, rstn, wr, rd, search_done, edit_mode;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, val;
  logic        cw_pulse, ccw_pulse, origin_undef, busy, irq;
  int          steps, errors, checks, cycles;

  pulse_position i_pulse_position (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .search_done(search_done), .edit_mode(edit_mode),
    .cw_pulse(cw_pulse), .ccw_pulse(ccw_pulse),
    .origin_undef(origin_undef), .busy(busy), .irq(irq));
  motor_driver_model i_motor_driver_model (.cw_pulse(cw_pulse),
    .ccw_pulse(ccw_pulse), .steps(steps));

  // 125 MHz clock
  always #4 clk = ~clk;

  // hang guard: the whole run of a few short moves needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bus cycles: one strobe cycle, read data the cycle after
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // issue one command, wait out the move, judge steps and position
  task move(input logic [31:0] set, input logic abs, input logic ccw,
            input logic [31:0] pos_exp, input int delta);
    int s0;
    int n;
    s0 = steps;
    n  = 0;
    wr_reg(ADDR_TARGET, set);
    wr_reg(ADDR_CMD, {30'h0, ccw, abs});
    chk("busy", {31'h0, busy}, {31'h0, delta != 0});
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("steps", 32'(steps - s0), 32'(delta));
    rd_reg(ADDR_POS, val);
    chk("position", val, pos_exp);
  endtask : move

  task t_reset;
    rd_reg(ADDR_STATUS, val);
    chk("status", val, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0);
    rd_reg(4'hf, val);
    chk("unmapped", val, 32'h0);
  endtask : t_reset

  task t_relative;
    wr_reg(ADDR_MASK, 32'h0000_0003);
    move(32'h0000_0002, 1'b0, 1'b1, 32'hffff_fffe, -2);
    move(32'h0000_0003, 1'b0, 1'b0, 32'h0000_0003, 3);
    rd_reg(ADDR_IRQ, val);
    chk("done stat", val, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h1);
    wr_reg(ADDR_IRQ, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask : t_relative

  task t_refuse;
    move(32'h0000_0005, 1'b1, 1'b0, 32'h0000_0003, 0);
    rd_reg(ADDR_IRQ, val);
    chk("err stat", val, 32'h0000_0002);
    chk("irq", {31'h0, irq}, 32'h1);
    // masking hides the error without clearing it
    wr_reg(ADDR_MASK, 32'h0000_0001);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(ADDR_MASK, 32'h0000_0003);
    wr_reg(ADDR_IRQ, 32'h0000_0002);
  endtask : t_refuse

  task t_absolute;
    wr_reg(ADDR_PRESET, 32'h7fff_fffe);
    chk("origin_undef", {31'h0, origin_undef}, 32'h0);
    move(32'h0000_0001, 1'b0, 1'b0, 32'h7fff_ffff, 1);
    wr_reg(ADDR_PRESET, 32'hffff_fffe);
    move(32'h0000_0001, 1'b1, 1'b0, 32'h0000_0001, 3);
    move(32'hffff_fffd, 1'b1, 1'b0, 32'hffff_fffd, -4);
  endtask : t_absolute

  task t_origin;
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    // the held control bit undefines the origin one edge later
    @(posedge clk);
    #1;
    chk("origin_undef", {31'h0, origin_undef}, 32'h1);
    wr_reg(ADDR_CTRL, 32'h0);
    @(posedge clk);
    search_done <= 1'b1;
    repeat (6) @(posedge clk);
    search_done <= 1'b0;
    #1;
    chk("origin_undef", {31'h0, origin_undef}, 32'h0);
    @(posedge clk);
    edit_mode <= 1'b1;
    repeat (6) @(posedge clk);
    edit_mode <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("origin_undef", {31'h0, origin_undef}, 32'h1);
    // back in the relative frame the counter restarts from zero
    move(32'h0000_0002, 1'b0, 1'b0, 32'h0000_0002, 2);
    // a zero-length relative move still clears the counter
    move(32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000, 0);
  endtask : t_origin

  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    clk         = 1'b0;
    rstn        = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = 4'h0;
    wdata       = 32'h0;
    search_done = 1'b0;
    edit_mode   = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_relative();
    t_refuse();
    t_absolute();
    t_origin();
    conclude();
  end
endmodule : pulse_position_bench
`default_nettype wire
